// file: rtl/infmap_pkg.sv
// Package: constants for the input function mapper.
// Assumes a single 20 MHz clock domain and classic Wishbone register access.
package infmap_pkg;
   localparam int NUM_TERMS = 8;
   localparam int CODE_W = 6;
   localparam int CLK_HZ = 20_000_000;
   // Function codes
   localparam logic [5:0] FN_UNUSED = 6'h00;
   localparam logic [5:0] FN_CONT_POS = 6'h01;
   localparam logic [5:0] FN_CONT_NEG = 6'h02;
   localparam logic [5:0] FN_HOME = 6'h03;
   localparam logic [5:0] FN_START = 6'h04;
   localparam logic [5:0] FN_SEQ_POS = 6'h05;
   localparam logic [5:0] FN_JOG_POS = 6'h06;
   localparam logic [5:0] FN_JOG_NEG = 6'h07;
   localparam logic [5:0] FN_DPOS_SEL0 = 6'h08;
   localparam logic [5:0] FN_FREE = 6'h10;
   localparam logic [5:0] FN_EXCITE_ON = 6'h11;
   localparam logic [5:0] FN_STOP = 6'h12;
   localparam logic [5:0] FN_ALARM_CLEAR = 6'h18;
   localparam logic [5:0] FN_POS_PRESET = 6'h19;
   localparam logic [5:0] FN_POS_ERR_CLEAR = 6'h1a;
   localparam logic [5:0] FN_PANEL_UNLOCK = 6'h1b;
   localparam logic [5:0] FN_GENERAL_0 = 6'h20;
   localparam logic [5:0] FN_OP_SEL0 = 6'h30;
   localparam logic [5:0] FN_OP_SEL5 = 6'h35;
   // Register byte addresses
   localparam logic [3:0] ADDR_SEL_LO = 4'h0;
   localparam logic [3:0] ADDR_SEL_HI = 4'h4;
   localparam logic [3:0] ADDR_POL = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;
   // Reset values
   localparam logic [47:0] SEL_RESET = {FN_ALARM_CLEAR, FN_STOP, FN_FREE, 6'h32, 6'h31,
                                        FN_OP_SEL0, FN_START, FN_HOME};
   localparam logic [7:0] POL_RESET = 8'h00;
   localparam int SYNC_STAGES = 3;
endpackage

// file: rtl/infmap_sync.sv
// Three-stage synchroniser for the raw terminal pins, with agreement filter.
// Assumes pins are asynchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none
module infmap_sync #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else if (i_ce) begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // A bit only moves once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_sync <= '0;
      end else if (i_ce) begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               o_sync[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule // infmap_sync
`default_nettype wire

// file: rtl/input_function_mapper.sv
// Input function mapper: maps eight terminals onto driver command functions.
// Assumes raw pins are asynchronous; network copies come from logic on i_clk.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module input_function_mapper
   import infmap_pkg::*;
#(
   parameter int TERMS = infmap_pkg::NUM_TERMS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Terminals (high = contact closed)
   input wire logic [TERMS-1:0] i_term,
   // Network copies of excitation-on and panel-unlock
   input wire logic i_net_excite_on,
   input wire logic i_net_excite_on_assigned,
   input wire logic i_net_panel_unlock,
   input wire logic i_net_panel_unlock_assigned,
   // Function outputs
   output logic [5:0] o_op_data_no,
   output logic o_continuous_positive,
   output logic o_continuous_negative,
   output logic o_home,
   output logic o_start,
   output logic o_sequential_positioning,
   output logic o_jog_positive,
   output logic o_jog_negative,
   output logic [5:0] o_direct_position_sel,
   output logic o_free,
   output logic o_excite_on,
   output logic o_stop,
   output logic o_motor_excite_en,
   output logic o_brake_release,
   output logic o_alarm_clear_pulse,
   output logic o_position_preset_pulse,
   output logic o_position_error_clear_pulse,
   output logic o_panel_unlock,
   output logic [15:0] o_general_signal
);
   logic [5:0] sel_reg [TERMS];
   logic [TERMS-1:0] pol_reg;
   logic [TERMS-1:0] raw_sync;
   logic [TERMS-1:0] active_reg;
   logic [63:0] func_next;
   logic [63:0] func_reg;
   logic [63:0] assigned_next;
   logic wb_req;
   logic [31:0] rd_next;

   infmap_sync #(
      .WIDTH(TERMS)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_async(i_term),
      .o_sync(raw_sync)
   );

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw,
                                              input logic lane);
      merge_byte = lane ? nw : old;
   endfunction

   assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

   // Function select and polarity registers; four 6-bit codes per word
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int t = 0; t < TERMS; t++) begin
            sel_reg[t] <= SEL_RESET[t*6 +: 6];
         end
         pol_reg <= POL_RESET[TERMS-1:0];
      end else if (i_ce && wb_req && i_wb_we) begin
         for (int t = 0; t < TERMS; t++) begin
            if ((t < 4 && i_wb_adr == ADDR_SEL_LO) || (t >= 4 && i_wb_adr == ADDR_SEL_HI)) begin
               if (i_wb_sel[t % 4]) begin
                  sel_reg[t] <= i_wb_dat[(t % 4)*8 +: 6];
               end
            end
         end
         if (i_wb_adr == ADDR_POL) begin
            pol_reg <= merge_byte(pol_reg, i_wb_dat[7:0], i_wb_sel[0]);
         end
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (i_wb_adr)
         ADDR_SEL_LO: begin
            for (int t = 0; t < 4; t++) begin
               rd_next[t*8 +: 6] = sel_reg[t];
            end
         end
         ADDR_SEL_HI: begin
            for (int t = 4; t < TERMS; t++) begin
               rd_next[(t-4)*8 +: 6] = sel_reg[t];
            end
         end
         ADDR_POL: rd_next[7:0] = pol_reg;
         ADDR_STATUS: rd_next[7:0] = active_reg;
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // Ack one cycle after the request; unmapped addresses read zero
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else if (i_ce) begin
         o_wb_ack <= wb_req;
         if (wb_req && !i_wb_we) begin
            o_wb_dat <= rd_next;
         end
      end
   end

   // Registered, polarity-corrected sample of each terminal
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         active_reg <= '0;
      end else if (i_ce) begin
         active_reg <= raw_sync ^ pol_reg;
      end
   end

   // Decode every terminal not set to FN_UNUSED onto a one-hot function vector, then OR-merge
   always_comb begin
      func_next = 64'h0;
      assigned_next = 64'h0;
      for (int t = 0; t < TERMS; t++) begin
         if (sel_reg[t] != FN_UNUSED) begin
            assigned_next[sel_reg[t]] = 1'b1;
            func_next[sel_reg[t]] = func_next[sel_reg[t]] | active_reg[t];
         end
      end
      // Unassigned excitation and unlock count as on
      if (!assigned_next[FN_EXCITE_ON]) begin
         func_next[FN_EXCITE_ON] = 1'b1;
      end
      if (!assigned_next[FN_PANEL_UNLOCK]) begin
         func_next[FN_PANEL_UNLOCK] = 1'b1;
      end
      // Network copy gates the direct one when both exist
      if (i_net_excite_on_assigned) begin
         func_next[FN_EXCITE_ON] = func_next[FN_EXCITE_ON] & i_net_excite_on;
      end
      if (i_net_panel_unlock_assigned) begin
         func_next[FN_PANEL_UNLOCK] = func_next[FN_PANEL_UNLOCK] & i_net_panel_unlock;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         func_reg <= 64'h0;
      end else if (i_ce) begin
         func_reg <= func_next;
      end
   end

   // Level functions
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_op_data_no <= 6'h00;
         o_continuous_positive <= 1'b0;
         o_continuous_negative <= 1'b0;
         o_home <= 1'b0;
         o_start <= 1'b0;
         o_sequential_positioning <= 1'b0;
         o_jog_positive <= 1'b0;
         o_jog_negative <= 1'b0;
         o_direct_position_sel <= 6'h00;
         o_free <= 1'b0;
         o_excite_on <= 1'b0;
         o_stop <= 1'b0;
         o_motor_excite_en <= 1'b0;
         o_brake_release <= 1'b0;
         o_panel_unlock <= 1'b0;
         o_general_signal <= 16'h0000;
      end else if (i_ce) begin
         o_op_data_no <= func_reg[FN_OP_SEL0 +: 6];
         o_continuous_positive <= func_reg[FN_CONT_POS];
         o_continuous_negative <= func_reg[FN_CONT_NEG];
         o_home <= func_reg[FN_HOME];
         o_start <= func_reg[FN_START];
         o_sequential_positioning <= func_reg[FN_SEQ_POS];
         o_jog_positive <= func_reg[FN_JOG_POS];
         o_jog_negative <= func_reg[FN_JOG_NEG];
         o_direct_position_sel <= func_reg[FN_DPOS_SEL0 +: 6];
         o_free <= func_reg[FN_FREE];
         o_excite_on <= func_reg[FN_EXCITE_ON];
         o_stop <= func_reg[FN_STOP];
         // Free overrides excitation and frees the brake
         o_motor_excite_en <= func_reg[FN_EXCITE_ON] && !func_reg[FN_FREE];
         o_brake_release <= func_reg[FN_FREE];
         o_panel_unlock <= func_reg[FN_PANEL_UNLOCK];
         o_general_signal <= func_reg[FN_GENERAL_0 +: 16];
      end
   end

   // Edge-executed functions: one-cycle pulses
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_alarm_clear_pulse <= 1'b0;
         o_position_error_clear_pulse <= 1'b0;
         o_position_preset_pulse <= 1'b0;
      end else if (i_ce) begin
         o_alarm_clear_pulse <= func_reg[FN_ALARM_CLEAR] && !func_next[FN_ALARM_CLEAR];
         o_position_error_clear_pulse <=
            func_reg[FN_POS_ERR_CLEAR] && !func_next[FN_POS_ERR_CLEAR];
         o_position_preset_pulse <= !func_reg[FN_POS_PRESET] && func_next[FN_POS_PRESET];
      end
   end
endmodule // input_function_mapper
`default_nettype wire

// file: test/term_switches.sv
// Partner: bank of switches or host outputs wired to the eight terminals.
// Assumes the bench sets new levels just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module term_switches (
   input wire logic i_clk,
   input wire logic [7:0] i_set,
   output logic [7:0] o_term
);
   // One clock late, so contacts never move on the edge the mapper samples
   always_ff @(posedge i_clk) begin
      o_term <= i_set;
   end
endmodule // term_switches
`default_nettype wire

// file: test/infmap_props.sv
// Checker: port properties of the input function mapper.
// Assumes one i_clk domain; bound to every mapper instance.
`timescale 1ns/100ps
`default_nettype none
module infmap_props (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire logic i_net_excite_on,
   input wire logic i_net_excite_on_assigned,
   input wire logic o_excite_on,
   input wire logic o_free,
   input wire logic o_brake_release,
   input wire logic o_motor_excite_en,
   input wire logic o_alarm_clear_pulse,
   input wire logic o_position_preset_pulse,
   input wire logic o_position_error_clear_pulse
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_req; i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
   // Held off longer than the whole input pipeline
   sequence s_net_off; (i_net_excite_on_assigned && !i_net_excite_on)[*8]; endsequence
   property p_ack; s_req |=> o_wb_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack_once; o_wb_ack && i_ce |=> !o_wb_ack; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_alarm; o_alarm_clear_pulse && i_ce |=> !o_alarm_clear_pulse; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm clear not a pulse");
   property p_perr; o_position_error_clear_pulse |=> !o_position_error_clear_pulse; endproperty
   a_perr: assert property (p_perr) else $error("error clear not a pulse");
   property p_preset; o_position_preset_pulse |=> !o_position_preset_pulse; endproperty
   a_preset: assert property (p_preset) else $error("preset not a pulse");
   // Two cycles allowed, as the outputs may be registered one behind the other
   property p_brake; (o_free[*2] |-> o_brake_release) and ((!o_free)[*2] |-> !o_brake_release);
   endproperty
   a_brake: assert property (p_brake) else $error("brake not following free");
   property p_free_off; o_free[*2] |-> !o_motor_excite_en; endproperty
   a_free_off: assert property (p_free_off) else $error("excited while free");
   property p_net_and; s_net_off |-> !o_excite_on; endproperty
   a_net_and: assert property (p_net_and) else $error("excite on without network");
endmodule // infmap_props
bind input_function_mapper infmap_props u_props (.*);
`default_nettype wire

// file: test/input_function_mapper_test.sv
// Testbench: drives bus and terminals, compares outputs with a behavioural model.
// Assumes the term_switches partner and the bound infmap_props checker.
`timescale 1ns/100ps
`default_nettype none
module input_function_mapper_test;
   import infmap_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic [3:0] i_wb_adr = 4'h0;
   logic [3:0] i_wb_sel = 4'hf;
   logic [31:0] i_wb_dat = 32'h0;
   logic [31:0] o_wb_dat, rdat;
   logic o_wb_ack, o_home, o_start, o_free, o_stop, o_excite_on, o_panel_unlock;
   logic o_alarm_clear_pulse, o_position_preset_pulse, o_position_error_clear_pulse;
   logic [5:0] o_op_data_no;
   logic cpos;
   logic [5:0] dsel;
   logic [15:0] gsig;
   logic [7:0] term_set = 8'h00;
   logic [7:0] i_term;
   logic [3:0] net = 4'h0;
   logic [7:0] pol_m = 8'h00;
   logic [31:0] lfsr = 32'h8abcebca;
   int code_m[8] = '{3, 4, 48, 49, 50, 16, 18, 24};
   int lst[15] = '{0, 3, 4, 16, 17, 18, 27, 48, 49, 51, 52, 53, 1, 8, 32};
   int num_errors = 0;
   int checks_done = 0;
   always #25 i_clk = ~i_clk;
   term_switches u_sw (.i_clk(i_clk), .i_set(term_set), .o_term(i_term));
   input_function_mapper DUT (.*, .i_net_excite_on(net[0]), .i_net_excite_on_assigned(net[1]),
      .i_net_panel_unlock(net[2]), .i_net_panel_unlock_assigned(net[3]),
      .o_continuous_positive(cpos), .o_continuous_negative(), .o_sequential_positioning(),
      .o_jog_positive(), .o_jog_negative(), .o_direct_position_sel(dsel),
      .o_motor_excite_en(), .o_brake_release(), .o_general_signal(gsig));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Called just after an edge; leaves one idle cycle behind it
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k = 0;
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_wb_ack !== 1'b1 && k < 20);
      rdat = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      if (k >= 20) begin
         num_errors++;
         stop_test();
      end
      @(posedge i_clk);
   endtask
   task automatic cfg();
      logic [31:0] v[2] = '{32'h0, 32'h0};
      for (int i = 0; i < 8; i++) v[i / 4][8 * (i % 4) +: 6] = 6'(code_m[i]);
      wb(1'b1, ADDR_SEL_LO, v[0]);
      wb(1'b1, ADDR_SEL_HI, v[1]);
      wb(1'b1, ADDR_POL, {24'h0, pol_m});
   endtask
   task automatic check_funcs();
      logic [7:0] a = term_set ^ pol_m;
      logic [5:0] op;
      bit hit[64];
      bit has[64];
      for (int i = 0; i < 8; i++) begin
         has[code_m[i]] = 1'b1;
         hit[code_m[i]] |= a[i];
      end
      for (int b = 0; b < 6; b++) op[b] = hit[48 + b];
      cmp("op_data_no", 32'(op), 32'(o_op_data_no));
      cmp("home", 32'(hit[3]), 32'(o_home));
      cmp("start", 32'(hit[4]), 32'(o_start));
      cmp("free", 32'(hit[16]), 32'(o_free));
      cmp("stop", 32'(hit[18]), 32'(o_stop));
      cmp("cont_pos", 32'(hit[1]), 32'(cpos));
      cmp("dpos_sel", 32'(hit[8]), 32'(dsel));
      cmp("general", 32'(hit[32]), 32'(gsig));
      cmp("excite", 32'((has[17] ? hit[17] : 1) & (net[1] ? net[0] : 1)), 32'(o_excite_on));
      cmp("unlock", 32'((has[27] ? hit[27] : 1) & (net[3] ? net[2] : 1)), 32'(o_panel_unlock));
      wb(1'b0, ADDR_STATUS, 32'h0);
      cmp("status", {24'h0, a}, rdat);
   endtask
   task automatic count(input int c, output int n);
      n = 0;
      repeat (12) begin
         @(posedge i_clk);
         n += int'({o_alarm_clear_pulse, o_position_preset_pulse,
            o_position_error_clear_pulse} == 3'(3'b100 >> (c - 24)));
      end
   endtask
   initial begin
      int cr, cf;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      wb(1'b0, ADDR_SEL_LO, 32'h0);
      cmp("sel_lo", 32'h31300403, rdat);
      wb(1'b0, ADDR_SEL_HI, 32'h0);
      cmp("sel_hi", 32'h18121032, rdat);
      wb(1'b0, ADDR_POL, 32'h0);
      cmp("pol", 32'h0, rdat);
      wb(1'b1, 4'h2, 32'hffffffff);
      wb(1'b0, 4'h2, 32'h0);
      cmp("unmapped", 32'h0, rdat);
      // Random codes may repeat, which exercises the merge of shared functions
      for (int n = 0; n < 24; n++) begin
         if (n % 4 == 3) begin
            for (int i = 0; i < 8; i++) begin
               lfsr = nx(lfsr);
               code_m[i] = lst[lfsr % 15];
            end
            pol_m = lfsr[15:8];
            cfg();
         end
         lfsr = nx(lfsr);
         term_set <= lfsr[7:0];
         net <= lfsr[11:8];
         repeat (12) @(posedge i_clk);
         check_funcs();
      end
      code_m = '{default: 0};
      pol_m = 8'h00;
      term_set <= 8'h00;
      for (int c = 24; c < 27; c++) begin
         code_m[7] = c;
         cfg();
         repeat (12) @(posedge i_clk);
         term_set <= 8'h80;
         count(c, cr);
         term_set <= 8'h00;
         count(c, cf);
         cmp("rise_pulses", 32'(c == 25), 32'(cr));
         cmp("fall_pulses", 32'(c != 25), 32'(cf));
      end
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge i_clk);
      num_errors++;
      stop_test();
   end
endmodule // input_function_mapper_test
`default_nettype wire
